/* logic/pcrc_pkg.sv */
// Constants, register map and field layout of the programmable CRC engine.
// Assumes a 32-bit AXI4-Lite master and a single 100 MHz clock.
//
// Functional notes
// - Select 1: interrupt once the FIFO runs empty.
// - Select 0: interrupt when all shifting is done.
// - Control two bits 12-8: data width minus one.
// - Control two bits 4-0: polynomial length minus one.
// - Low terms 15-1 enable feedback; bit 0 reads zero.
// - Input word writes push FIFO; reads return zero.
// - Shift pair writes load register, reads return result.
// - High terms 15-0 enable feedback terms 31-16.
package pcrc_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL1  = 8'h00;
	localparam logic [7:0] OFS_CTRL2  = 8'h04;
	localparam logic [7:0] OFS_XOR_LO = 8'h08;
	localparam logic [7:0] OFS_XOR_HI = 8'h0C;
	localparam logic [7:0] OFS_DAT_LO = 8'h10;
	localparam logic [7:0] OFS_DAT_HI = 8'h14;
	localparam logic [7:0] OFS_SH_LO  = 8'h18;
	localparam logic [7:0] OFS_SH_HI  = 8'h1C;
	localparam logic [7:0] OFS_IRQ_ST = 8'h20;
	localparam logic [7:0] OFS_IRQ_MK = 8'h24;
	// ==========================================================
	// Field positions in control one
	localparam int POS_CNT   = 8;
	localparam int POS_FULL  = 7;
	localparam int POS_EMPTY = 6;
	localparam int POS_ISEL  = 5;
	localparam int POS_GO    = 4;
	localparam int POS_ORDER = 3;
	// Field positions in control two
	localparam int POS_DW = 8;
	localparam int POS_PL = 0;
	// ==========================================================
	// FIFO sizing and reset values
	localparam logic [4:0] FIFO_DEPTH_SHORT = 5'h10;
	localparam logic [4:0] FIFO_DEPTH_LONG  = 5'h08;
	localparam logic [4:0] POLY_LENGTH_FIELD_LONG_MIN    = 5'h07;
	localparam logic [31:0] RST_CRC         = 32'h00000000;
	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* logic/pcrc_step.sv */
// One serial step of the CRC shifter.
// Assumes poly bit 0 is the implied x^0 term and crc is zero above the length.
`timescale 1ns/1ps
`default_nettype none
module pcrc_step (
	// Current state and setup
	input  wire logic [31:0] crc,
	input  wire logic [31:0] poly,
	input  wire logic [4:0]  poly_length_field,
	input  wire logic        din,
	// Next state
	output logic      [31:0] nxt
);
	// Feedback from the top bit of the active length, masked to the length
	function automatic logic [31:0] step(input logic [31:0] c, input logic [31:0] p,
		input logic [4:0] l, input logic d);
		logic [31:0] v;
		logic [31:0] m;
		v = {c[30:0], 1'b0};
		if (d ^ c[l]) begin
			v = v ^ {p[31:1], 1'b1};
		end
		m = 32'hFFFFFFFF >> (5'h1F - l);
		return v & m;
	endfunction

	// Combinational step
	always_comb begin
		nxt = step(crc, poly, poly_length_field, din);
	end
endmodule // pcrc_step
`default_nettype wire

/* logic/pcrc_top.sv */
// Programmable CRC engine with input FIFO, serial shifter and AXI4-Lite registers.
// Assumes a synchronous active-low reset and a master that keeps one write and one read open.
`timescale 1ns/1ps
`default_nettype none
module pcrc_top (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write address and data
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// Write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// Read address and data
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Interrupt
	output logic             irq
);
	import pcrc_pkg::*;

	// ==========================================================
	// State
	typedef enum logic [1:0] {
		PCRC_IDLE  = 2'b01,
		PCRC_SHIFT = 2'b10
	} pcrc_fsm_t;

	typedef struct packed {
		logic [15:0][31:0] mem;
		logic [3:0]        wptr;
		logic [3:0]        rptr;
		logic [4:0]        cnt;
		logic [31:0]       crc;
		logic [31:0]       poly;
		logic [4:0]        dw;
		logic [4:0]        pl;
		logic              isel;
		logic              go;
		logic              order;
		logic [31:0]       word;
		logic [4:0]        left;
		pcrc_fsm_t         fsm;
		logic              sts;
		logic              mask;
		logic              irq;
		logic              awrdy;
		logic              wrdy;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arrdy;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} pcrc_state_t;

	pcrc_state_t s_q;
	pcrc_state_t s_d;
	logic [31:0] step_nxt;
	logic        step_bit;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// FIFO limit for the current length code
	function automatic logic [4:0] depth(input logic [4:0] pl);
		return (pl >= POLY_LENGTH_FIELD_LONG_MIN) ? FIFO_DEPTH_LONG : FIFO_DEPTH_SHORT;
	endfunction

	// Address decode
	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= OFS_IRQ_MK);
	endfunction

	// Serial input bit by shift direction
	assign step_bit = s_q.order ? s_q.word[0] : s_q.word[s_q.dw];

	pcrc_step u_step (
		.crc  (s_q.crc),
		.poly (s_q.poly),
		.poly_length_field (s_q.pl),
		.din  (step_bit),
		.nxt  (step_nxt)
	);

	// ==========================================================
	// Next state
	always_comb begin
		logic       wr;
		logic       push;
		logic [31:0] pv;
		logic [31:0] c1;
		logic [31:0] cm;
		wr   = 1'b0;
		push = 1'b0;
		pv   = 32'h00000000;
		c1   = 32'h00000000;
		cm   = 32'h00000000;
		s_d  = s_q;

		// Write channel: take address and data together
		s_d.awrdy = 1'b0;
		s_d.wrdy  = 1'b0;
		if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end
		if (awvalid && wvalid && !s_q.bvalid && !s_q.awrdy) begin
			s_d.awrdy = 1'b1;
			s_d.wrdy  = 1'b1;
		end
		if (s_q.awrdy && awvalid && wvalid) begin
			wr         = 1'b1;
			s_d.bvalid = 1'b1;
			s_d.bresp  = mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
		end

		// Register writes
		if (wr) begin
			c1 = merge({26'h0000000, s_q.isel, s_q.go, s_q.order, 3'h0}, wdata, wstrb);
			cm = merge(s_q.crc, wdata, wstrb);
			case (awaddr)
				OFS_CTRL1: begin
					s_d.isel  = c1[POS_ISEL];
					s_d.go    = c1[POS_GO];
					s_d.order = c1[POS_ORDER];
				end
				OFS_CTRL2: begin
					c1     = merge({19'h0, s_q.dw, 3'h0, s_q.pl}, wdata, wstrb);
					s_d.dw = c1[POS_DW +: 5];
					s_d.pl = c1[POS_PL +: 5];
				end
				OFS_XOR_LO: begin
					c1 = merge({16'h0000, s_q.poly[15:0]}, wdata, wstrb);
					s_d.poly[15:0] = {c1[15:1], 1'b0};
				end
				OFS_XOR_HI: begin
					c1 = merge({16'h0000, s_q.poly[31:16]}, wdata, wstrb);
					s_d.poly[31:16] = c1[15:0];
				end
				OFS_DAT_LO: begin
					push = 1'b1;
					pv   = {16'h0000, wdata[15:0]};
				end
				OFS_DAT_HI: begin
					push = 1'b1;
					pv   = {wdata[15:0], 16'h0000};
				end
				OFS_SH_LO:  s_d.crc[15:0]  = cm[15:0];
				OFS_SH_HI:  s_d.crc[31:16] = cm[15:0];
				OFS_IRQ_ST: s_d.sts = s_q.sts & ~(wdata[0] & wstrb[0]);
				OFS_IRQ_MK: begin
					// Only bit 0 is stored; upper bits are ignored
					c1       = merge({31'h0, s_q.mask}, wdata, wstrb);
					s_d.mask = c1[0];
				end
				default: ;
			endcase
		end

		// FIFO push, dropped while full
		if (push && s_q.cnt < depth(s_q.pl)) begin
			s_d.mem[s_q.wptr] = pv;
			s_d.wptr          = s_q.wptr + 4'h1;
			s_d.cnt           = s_q.cnt + 5'h01;
		end

		// Shifter
		case (s_q.fsm)
			PCRC_IDLE: begin
				if (s_q.go && s_q.cnt != 5'h00 && !push) begin
					s_d.word = s_q.mem[s_q.rptr];
					s_d.rptr = s_q.rptr + 4'h1;
					s_d.cnt  = s_q.cnt - 5'h01;
					s_d.left = s_q.dw;
					s_d.fsm  = PCRC_SHIFT;
					if (s_q.isel && s_q.cnt == 5'h01) begin
						s_d.sts = 1'b1;
					end
				end
			end
			PCRC_SHIFT: begin
				if (!(wr && (awaddr == OFS_SH_LO || awaddr == OFS_SH_HI))) begin
					s_d.crc = step_nxt;
				end
				s_d.word = s_q.order ? {1'b0, s_q.word[31:1]} : {s_q.word[30:0], 1'b0};
				if (s_q.left == 5'h00) begin
					s_d.fsm = PCRC_IDLE;
					if (s_q.cnt == 5'h00) begin
						s_d.go = 1'b0;
						if (!s_q.isel) begin
							s_d.sts = 1'b1;
						end
					end
				end else begin
					s_d.left = s_q.left - 5'h01;
				end
			end
			default: s_d.fsm = PCRC_IDLE;
		endcase

		// Read channel
		s_d.arrdy = 1'b0;
		if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end
		if (arvalid && !s_q.rvalid && !s_q.arrdy) begin
			s_d.arrdy = 1'b1;
		end
		if (s_q.arrdy && arvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			case (araddr)
				OFS_CTRL1: s_d.rdata = {19'h0, s_q.cnt, s_q.cnt == depth(s_q.pl),
					s_q.cnt == 5'h00, s_q.isel, s_q.go, s_q.order, 3'h0};
				OFS_CTRL2:  s_d.rdata = {19'h0, s_q.dw, 3'h0, s_q.pl};
				OFS_XOR_LO: s_d.rdata = {16'h0000, s_q.poly[15:1], 1'b0};
				OFS_XOR_HI: s_d.rdata = {16'h0000, s_q.poly[31:16]};
				OFS_SH_LO:  s_d.rdata = {16'h0000, s_q.crc[15:0]};
				OFS_SH_HI:  s_d.rdata = {16'h0000, s_q.crc[31:16]};
				OFS_IRQ_ST: s_d.rdata = {31'h0, s_q.sts};
				OFS_IRQ_MK: s_d.rdata = {31'h0, s_q.mask};
				default:    s_d.rdata = 32'h00000000;
			endcase
		end

		// Set wins over a clear in the same cycle
		s_d.irq = s_d.sts & s_d.mask;
	end

	// Register the state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q     <= '0;
			s_q.fsm <= PCRC_IDLE;
			s_q.crc <= RST_CRC;
		end else begin
			s_q <= s_d;
		end
	end

	assign awready = s_q.awrdy;
	assign wready  = s_q.wrdy;
	assign bvalid  = s_q.bvalid;
	assign bresp   = s_q.bresp;
	assign arready = s_q.arrdy;
	assign rvalid  = s_q.rvalid;
	assign rdata   = s_q.rdata;
	assign rresp   = s_q.rresp;
	assign irq     = s_q.irq;

	// ==========================================================
	// Checks
	chk_fifo_limit: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(s_q.cnt == 5'h09) |-> $past(s_q.pl) < POLY_LENGTH_FIELD_LONG_MIN)
		else $error("fifo passed 8 words with a long polynomial");
	chk_irq_empty: assert property (@(posedge aclk) disable iff (!aresetn)
		s_q.isel && s_q.fsm == PCRC_IDLE && s_q.go && s_q.cnt == 5'h01
		&& !(s_q.awrdy && awvalid && wvalid && (awaddr == OFS_DAT_LO || awaddr == OFS_DAT_HI))
		|=> s_q.sts)
		else $error("empty interrupt missing");
	chk_irq_done: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(s_q.sts) && !$past(s_q.isel) |-> $past(s_q.fsm == PCRC_SHIFT && s_q.left == 5'h00))
		else $error("done interrupt before shifting finished");
	chk_width_load: assert property (@(posedge aclk) disable iff (!aresetn)
		s_q.fsm == PCRC_IDLE ##1 s_q.fsm == PCRC_SHIFT |-> s_q.left == s_q.dw)
		else $error("bit count not loaded from width field");
	chk_len_mask: assert property (@(posedge aclk) disable iff (!aresetn)
		s_q.fsm == PCRC_SHIFT
		&& !(s_q.awrdy && awvalid && wvalid && (awaddr == OFS_SH_LO || awaddr == OFS_SH_HI))
		|=> (s_q.crc >> s_q.pl) <= 32'h1)
		else $error("crc bits above polynomial length");
	chk_term_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		s_q.arrdy && arvalid && araddr == OFS_XOR_LO |=> rvalid && !rdata[0])
		else $error("term zero read as one");
	chk_dat_read: assert property (@(posedge aclk) disable iff (!aresetn)
		s_q.arrdy && arvalid && (araddr == OFS_DAT_LO || araddr == OFS_DAT_HI) |=> rdata == 32'h0)
		else $error("input word read not zero");
	chk_shift_load: assert property (@(posedge aclk) disable iff (!aresetn)
		s_q.awrdy && awvalid && wvalid && awaddr == OFS_SH_LO && wstrb == 4'hF
		|=> s_q.crc[15:0] == $past(wdata[15:0]))
		else $error("shift register load lost");
	chk_hi_terms: assert property (@(posedge aclk) disable iff (!aresetn)
		s_q.awrdy && awvalid && wvalid && awaddr == OFS_XOR_HI && wstrb == 4'hF
		|=> s_q.poly[31:16] == $past(wdata[15:0]))
		else $error("high terms not stored");
	chk_count_read: assert property (@(posedge aclk) disable iff (!aresetn)
		s_q.arrdy && arvalid && araddr == OFS_CTRL1
		|=> rdata[12:8] == $past(s_q.cnt) && rdata[POS_EMPTY] == ($past(s_q.cnt) == 5'h00))
		else $error("count or empty flag misread");
endmodule // pcrc_top
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the programmable CRC engine.
// Assumes pcrc_top with an AXI4-Lite slave and one level interrupt.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pcrc_pkg::*;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rv, ex;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	int          n_fail, checks_done;

	pcrc_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));

	// ==========================================================
	// Clock, checks and bus tasks
	always #5 aclk = ~aclk;

	task automatic report_and_stop();
		if (n_fail == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t %s seen %h want %h", $time, msg, seen, exp);
		end
	endtask

	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rv = rdata; resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic wait_irq();
		do @(posedge aclk); while (irq !== 1'b1);
	endtask

	task automatic wait_idle();
		do rd(OFS_CTRL1); while (rv[4] !== 1'b0);
	endtask

	// Serial reference: one bit a step, top data bit first
	function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic [31:0] w, input int wd,
		input int ln, input logic [31:0] p);
		logic        fb;
		logic [31:0] m;
		m = (ln == 32) ? 32'hFFFFFFFF : ((32'h1 << ln) - 32'h1);
		for (int i = wd; i >= 0; i--) begin
			fb = w[i] ^ c[ln-1];
			c = ((c << 1) ^ (fb ? (p | 32'h1) : 32'h0)) & m;
		end
		return c;
	endfunction

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		logic [7:0] tab [7] = '{OFS_CTRL2, OFS_XOR_LO, OFS_XOR_HI, OFS_SH_LO, OFS_SH_HI, OFS_IRQ_ST, OFS_IRQ_MK};
		rd(OFS_CTRL1); chk(rv, 32'h40, "ctrl one reset");
		foreach (tab[i]) begin
			rd(tab[i]); chk(rv, 32'h0, "reset value");
		end
		wr(8'h28, 32'hFFFF); chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
		rd(8'h28); chk({rv[29:0], resp}, {30'h0, RESP_SLVERR}, "unmapped read");
	endtask

	task automatic t_fields();
		wr(OFS_CTRL2, 32'hFFFFFFFF);
		chk({30'h0, resp}, {30'h0, RESP_OKAY}, "mapped write okay");
		rd(OFS_CTRL2); chk(rv, 32'h1F1F, "ctrl two fields");
		chk({30'h0, resp}, {30'h0, RESP_OKAY}, "mapped read okay");
		wr(OFS_IRQ_MK, 32'h3); rd(OFS_IRQ_MK); chk(rv, 32'h1, "mask keeps bit zero");
		wr(OFS_XOR_LO, 32'hFFFFFFFF); rd(OFS_XOR_LO); chk(rv, 32'hFFFE, "low terms");
		wr(OFS_XOR_HI, 32'hFFFFFFFF); rd(OFS_XOR_HI); chk(rv, 32'hFFFF, "high terms");
		wr(OFS_CTRL1, 32'h1F80); rd(OFS_CTRL1); chk(rv, 32'h40, "count read only");
		rd(OFS_DAT_LO); chk(rv, 32'h0, "input low reads");
		rd(OFS_DAT_HI); chk(rv, 32'h0, "input high reads");
		wr(OFS_SH_LO, 32'h1234ABCD); rd(OFS_SH_LO); chk(rv, 32'hABCD, "shift low load");
		wr(OFS_SH_HI, 32'h5555); rd(OFS_SH_HI); chk(rv, 32'h5555, "shift high load");
	endtask

	// Short polynomial: sixteen words, then drain with the interrupt masked
	task automatic t_fifo();
		wr(OFS_CTRL2, 32'h3);
		for (int i = 0; i < 17; i++) wr(OFS_DAT_LO, i);
		rd(OFS_CTRL1); chk(rv, 32'h1080, "short depth full");
		wr(OFS_IRQ_MK, 32'h0); wr(OFS_CTRL1, 32'h10);
		wait_idle(); chk(rv, 32'h40, "drained empty");
		rd(OFS_IRQ_ST); chk(rv, 32'h1, "status sticky");
		chk({31'h0, irq}, 32'h0, "masked irq");
		wr(OFS_IRQ_ST, 32'h1); rd(OFS_IRQ_ST); chk(rv, 32'h0, "status cleared");
	endtask

	// Eight-bit CRC over eight bytes, interrupt when shifting is done
	task automatic t_crc();
		wr(OFS_CTRL2, 32'h0707); wr(OFS_XOR_LO, 32'h6); wr(OFS_XOR_HI, 32'h0);
		wr(OFS_SH_LO, 32'h0); wr(OFS_SH_HI, 32'h0); wr(OFS_IRQ_MK, 32'h1);
		ex = 32'h0;
		for (int i = 0; i < 9; i++) begin
			wr(OFS_DAT_LO, 32'h30 + i);
			if (i < 8) ex = crc_ref(ex, 32'h30 + i, 7, 8, 32'h6);
		end
		rd(OFS_CTRL1); chk(rv, 32'h0880, "long depth full");
		wr(OFS_CTRL1, 32'h10); wait_irq();
		rd(OFS_CTRL1); chk(rv, 32'h40, "done at irq");
		rd(OFS_SH_LO); chk(rv, ex, "crc eight result");
		wr(OFS_IRQ_ST, 32'h1); rd(OFS_IRQ_ST); chk(rv, 32'h0, "status cleared");
		chk({31'h0, irq}, 32'h0, "irq dropped");
	endtask

	// Least significant bit first: reference is fed the bit-reversed byte
	task automatic t_lsb();
		logic [7:0] w8;
		logic [7:0] rb;
		w8 = 8'hC5;
		for (int i = 0; i < 8; i++) rb[i] = w8[7 - i];
		wr(OFS_SH_LO, 32'h0); wr(OFS_DAT_LO, {24'h0, w8});
		ex = crc_ref(32'h0, {24'h0, rb}, 7, 8, 32'h6);
		wr(OFS_CTRL1, 32'h18); wait_irq();
		rd(OFS_SH_LO); chk(rv, ex, "lsb first result");
		wr(OFS_IRQ_ST, 32'h1);
	endtask

	// Full 32-bit CRC, interrupt as the FIFO empties
	task automatic t_early();
		wr(OFS_CTRL2, 32'h1F1F); wr(OFS_XOR_HI, 32'h04C1); wr(OFS_XOR_LO, 32'h1DB6);
		wr(OFS_SH_LO, 32'hFFFF); wr(OFS_SH_HI, 32'hFFFF);
		wr(OFS_DAT_LO, 32'h1234); wr(OFS_DAT_HI, 32'hABCD);
		ex = crc_ref(32'hFFFFFFFF, 32'h1234, 31, 32, 32'h04C11DB6);
		ex = crc_ref(ex, 32'hABCD0000, 31, 32, 32'h04C11DB6);
		wr(OFS_CTRL1, 32'h30); wait_irq();
		rd(OFS_CTRL1); chk(rv & 32'h10, 32'h10, "still shifting at irq");
		wait_idle();
		rd(OFS_SH_LO); chk(rv, {16'h0, ex[15:0]}, "crc low half");
		rd(OFS_SH_HI); chk(rv, {16'h0, ex[31:16]}, "crc high half");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
		arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
		n_fail = 0; checks_done = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset(); t_fields(); t_fifo(); t_crc(); t_lsb(); t_early();
		report_and_stop();
	end

	initial begin
		#200000;
		n_fail++;
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
